// File: hw/dbsa_pkg.sv
// package: address map, arbitration modes and request carrier for the arbiter
package dbsa_pkg;

    // ****************************************************************
    // address map
    // ****************************************************************
    localparam logic [31:0] CODE_LIMIT   = 32'h2000_0000;
    localparam logic [31:0] PPB_LO       = 32'he004_0000;
    localparam logic [31:0] PPB_HI       = 32'he00f_ffff;
    localparam logic [31:0] FLASH_LO     = 32'h0000_0000;
    localparam logic [31:0] FLASH_HI     = 32'h07ff_ffff;
    localparam logic [31:0] DRAM_AL_LO   = 32'h0800_0000;
    localparam logic [31:0] DRAM_AL_HI   = 32'h0fff_ffff;
    localparam logic [31:0] NVM_LO       = 32'h1000_0000;
    localparam logic [31:0] NVM_HI       = 32'h13ff_ffff;
    localparam logic [31:0] ACCRAM_LO    = 32'h1400_0000;
    localparam logic [31:0] ACCRAM_HI    = 32'h17ff_ffff;
    localparam logic [31:0] EXTBUS_AL_LO = 32'h1800_0000;
    localparam logic [31:0] EXTBUS_AL_HI = 32'h1bff_ffff;
    localparam logic [31:0] SRAM_L_LO    = 32'h1c00_0000;
    localparam logic [31:0] SRAM_L_HI    = 32'h1fff_ffff;
    localparam logic [31:0] SRAM_U_LO    = 32'h2000_0000;
    localparam logic [31:0] SRAM_U_HI    = 32'h200f_ffff;

    // ****************************************************************
    // timing and modes
    // ****************************************************************
    localparam int unsigned SYS_IFETCH_WAIT = 1;
    localparam int unsigned SRR_BD_WINS     = 3;
    localparam logic [1:0]  SRR_CNT_RST     = 2'h0;

    typedef enum logic [1:0] {
        DBSA_FIXED_CPU,
        DBSA_FIXED_BD,
        DBSA_ROUND_ROBIN,
        DBSA_SPECIAL_RR
    } dbsa_mode_t;

    localparam dbsa_mode_t MODE_RST = DBSA_ROUND_ROBIN;

    typedef enum logic [2:0] {
        DBSA_T_NONE,
        DBSA_T_FLASH,
        DBSA_T_DRAM_AL,
        DBSA_T_NVM,
        DBSA_T_ACCRAM,
        DBSA_T_EXTBUS_AL,
        DBSA_T_SRAM_L,
        DBSA_T_SRAM_U
    } dbsa_tgt_t;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        ifetch;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dbsa_req_t;

    typedef struct packed {
        logic        done;
        logic        err;
        logic [31:0] rdata;
    } dbsa_rsp_t;

endpackage

// File: hw/dbsa_arbiter.sv
// dual-bank sram port arbiter with core-side bus steering
// What this block does
// - instruction and data code buses merge into one
// - core accesses above code region go system
// - system instruction fetch adds one wait state
// - flash, secondary flash, accel ram, lower sram mapped
// - dram and external aliases are core only
// - lower bank on code, upper on system
// - each bank access completes in one clock
// - three ports: code, system, backdoor
// - different-bank requests served in same cycle
// - per-bank arbitration mode from control register
// - fixed processor mode favours the core
// - fixed backdoor mode favours the backdoor
// - round robin alternates contested grants evenly
// - special round robin favours the backdoor more
// - both banks reset to round robin
module dbsa_arbiter #(
    parameter int unsigned WORDS_L = 1024,
    parameter int unsigned WORDS_U = 1024
) (
    // clock and reset
    input  wire logic                 MCLK_IN,
    input  wire logic                 RSTN_IN,
    // arbitration modes, misc_control_register fields
    input  wire logic [1:0]           MODE_L_IN,
    input  wire logic [1:0]           MODE_U_IN,
    // core instruction and data code buses
    input  wire dbsa_pkg::dbsa_req_t  INSTRUCTION_CODE_BUS_REQ_IN,
    input  wire dbsa_pkg::dbsa_req_t  DATA_CODE_BUS_REQ_IN,
    // core system bus and backdoor
    input  wire dbsa_pkg::dbsa_req_t  SYS_REQ_IN,
    input  wire dbsa_pkg::dbsa_req_t  BD_REQ_IN,
    // answers
    output dbsa_pkg::dbsa_rsp_t       CODE_RSP_OUT,
    output dbsa_pkg::dbsa_rsp_t       SYS_RSP_OUT,
    output dbsa_pkg::dbsa_rsp_t       BD_RSP_OUT,
    output logic                      PPB_SEL_OUT,
    output logic                      INSTRUCTION_CODE_BUS_SEL_OUT
);

    localparam int AW_L = $clog2(WORDS_L);
    localparam int AW_U = $clog2(WORDS_U);

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic dbsa_pkg::dbsa_tgt_t decode(input logic [31:0] a);
        dbsa_pkg::dbsa_tgt_t t;
        t = dbsa_pkg::DBSA_T_NONE;
        if (a <= dbsa_pkg::FLASH_HI) t = dbsa_pkg::DBSA_T_FLASH;
        else if (a <= dbsa_pkg::DRAM_AL_HI) t = dbsa_pkg::DBSA_T_DRAM_AL;
        else if (a <= dbsa_pkg::NVM_HI) t = dbsa_pkg::DBSA_T_NVM;
        else if (a <= dbsa_pkg::ACCRAM_HI) t = dbsa_pkg::DBSA_T_ACCRAM;
        else if (a <= dbsa_pkg::EXTBUS_AL_HI)
            t = dbsa_pkg::DBSA_T_EXTBUS_AL;
        else if (a <= dbsa_pkg::SRAM_L_HI) t = dbsa_pkg::DBSA_T_SRAM_L;
        else if (a >= dbsa_pkg::SRAM_U_LO && a <= dbsa_pkg::SRAM_U_HI)
            t = dbsa_pkg::DBSA_T_SRAM_U;
        return t;
    endfunction

    // decides a contested grant: 1 means backdoor wins
    function automatic logic bd_wins(input logic [1:0] mode,
                                     input logic       rr_bd,
                                     input logic [1:0] cnt);
        logic w;
        w = 1'b0;
        unique case (dbsa_pkg::dbsa_mode_t'(mode))
            dbsa_pkg::DBSA_FIXED_CPU:    w = 1'b0;
            dbsa_pkg::DBSA_FIXED_BD:     w = 1'b1;
            dbsa_pkg::DBSA_ROUND_ROBIN:  w = rr_bd;
            dbsa_pkg::DBSA_SPECIAL_RR:
                w = (cnt != 2'(dbsa_pkg::SRR_BD_WINS));
        endcase
        return w;
    endfunction

    // ****************************************************************
    // core side steering
    // ****************************************************************
    logic                code_pick_i;
    dbsa_pkg::dbsa_req_t code_req;
    dbsa_pkg::dbsa_req_t sys_req;
    logic                sys_ppb;
    logic                sys_if_hold;
    logic                wait_d, wait_q;

    // data side owns the code bus when both request; fetch retries
    always_comb begin
        code_pick_i = INSTRUCTION_CODE_BUS_REQ_IN.valid && !DATA_CODE_BUS_REQ_IN.valid;
        code_req    = code_pick_i ? INSTRUCTION_CODE_BUS_REQ_IN : DATA_CODE_BUS_REQ_IN;
        code_req.valid = code_req.valid &&
                         (code_req.addr < dbsa_pkg::CODE_LIMIT);
        sys_ppb     = SYS_REQ_IN.valid &&
                      SYS_REQ_IN.addr >= dbsa_pkg::PPB_LO &&
                      SYS_REQ_IN.addr <= dbsa_pkg::PPB_HI;
        sys_req     = SYS_REQ_IN;
        sys_req.valid = SYS_REQ_IN.valid && !sys_ppb &&
                        SYS_REQ_IN.addr >= dbsa_pkg::CODE_LIMIT;
        // a system fetch is held one cycle before it reaches the bank
        sys_if_hold = sys_req.valid && sys_req.ifetch && !wait_q;
        wait_d      = sys_if_hold;
        if (sys_if_hold) sys_req.valid = 1'b0;
    end

    // ****************************************************************
    // bank arbitration
    // ****************************************************************
    dbsa_pkg::dbsa_tgt_t t_code, t_sys, t_bd;
    logic cl_req, su_req, bdl_req, bdu_req;
    logic gl_bd, gu_bd;
    logic rr_l_d, rr_l_q, rr_u_d, rr_u_q;
    logic [1:0] cnt_l_d, cnt_l_q, cnt_u_d, cnt_u_q;
    logic [1:0] mode_l_d, mode_l_q, mode_u_d, mode_u_q;

    always_comb begin
        // modes act one clock after the pins change, so a fresh reset
        // always starts in round robin whatever the pins show
        mode_l_d = MODE_L_IN;
        mode_u_d = MODE_U_IN;
        t_code  = decode(code_req.addr);
        t_sys   = decode(sys_req.addr);
        t_bd    = decode(BD_REQ_IN.addr);
        cl_req  = code_req.valid && t_code == dbsa_pkg::DBSA_T_SRAM_L;
        su_req  = sys_req.valid && t_sys == dbsa_pkg::DBSA_T_SRAM_U;
        bdl_req = BD_REQ_IN.valid && t_bd == dbsa_pkg::DBSA_T_SRAM_L;
        bdu_req = BD_REQ_IN.valid && t_bd == dbsa_pkg::DBSA_T_SRAM_U;
        // only core-port-of-bank against backdoor can collide
        gl_bd   = bdl_req && (!cl_req ||
                  bd_wins(mode_l_q, rr_l_q, cnt_l_q));
        gu_bd   = bdu_req && (!su_req ||
                  bd_wins(mode_u_q, rr_u_q, cnt_u_q));
        rr_l_d  = rr_l_q;
        rr_u_d  = rr_u_q;
        cnt_l_d = cnt_l_q;
        cnt_u_d = cnt_u_q;
        if (cl_req && bdl_req) begin
            rr_l_d  = !gl_bd;
            cnt_l_d = (cnt_l_q == 2'(dbsa_pkg::SRR_BD_WINS)) ?
                      2'h0 : cnt_l_q + 2'h1;
        end
        if (su_req && bdu_req) begin
            rr_u_d  = !gu_bd;
            cnt_u_d = (cnt_u_q == 2'(dbsa_pkg::SRR_BD_WINS)) ?
                      2'h0 : cnt_u_q + 2'h1;
        end
    end

    // ****************************************************************
    // banks and answers
    // ****************************************************************
    logic [31:0] mem_l [WORDS_L];
    logic [31:0] mem_u [WORDS_U];
    dbsa_pkg::dbsa_rsp_t code_d, sys_d, bd_d;
    dbsa_pkg::dbsa_rsp_t code_q, sys_q, bd_q;
    logic [AW_L-1:0] al_c, al_b;
    logic [AW_U-1:0] au_s, au_b;

    always_comb begin
        al_c = code_req.addr[AW_L+1:2];
        al_b = BD_REQ_IN.addr[AW_L+1:2];
        au_s = sys_req.addr[AW_U+1:2];
        au_b = BD_REQ_IN.addr[AW_U+1:2];
        code_d = '0;
        sys_d  = '0;
        bd_d   = '0;
        // non-sram targets belong to other slaves; this block ignores all but backdoor alias hits
        code_d.done  = cl_req && !gl_bd;
        code_d.rdata = mem_l[al_c];
        sys_d.done   = su_req && !gu_bd;
        sys_d.rdata  = mem_u[au_s];
        bd_d.done    = gl_bd || gu_bd;
        bd_d.rdata   = gl_bd ? mem_l[al_b] : mem_u[au_b];
        // aliases are not reachable by non-core masters
        bd_d.err     = BD_REQ_IN.valid &&
                       (t_bd == dbsa_pkg::DBSA_T_DRAM_AL ||
                        t_bd == dbsa_pkg::DBSA_T_EXTBUS_AL);
    end

    always_ff @(posedge MCLK_IN) begin
        if (code_d.done && code_req.write) mem_l[al_c] <= code_req.wdata;
        else if (gl_bd && BD_REQ_IN.write) mem_l[al_b] <= BD_REQ_IN.wdata;
        if (sys_d.done && sys_req.write) mem_u[au_s] <= sys_req.wdata;
        else if (gu_bd && BD_REQ_IN.write) mem_u[au_b] <= BD_REQ_IN.wdata;
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RSTN_IN) begin
            wait_q  <= 1'b0;
            mode_l_q <= dbsa_pkg::MODE_RST;
            mode_u_q <= dbsa_pkg::MODE_RST;
            rr_l_q  <= 1'b0;
            rr_u_q  <= 1'b0;
            cnt_l_q <= dbsa_pkg::SRR_CNT_RST;
            cnt_u_q <= dbsa_pkg::SRR_CNT_RST;
            code_q  <= '0;
            sys_q   <= '0;
            bd_q    <= '0;
            PPB_SEL_OUT   <= 1'b0;
            INSTRUCTION_CODE_BUS_SEL_OUT <= 1'b0;
        end else begin
            wait_q  <= wait_d;
            mode_l_q <= mode_l_d;
            mode_u_q <= mode_u_d;
            rr_l_q  <= rr_l_d;
            rr_u_q  <= rr_u_d;
            cnt_l_q <= cnt_l_d;
            cnt_u_q <= cnt_u_d;
            code_q  <= code_d;
            sys_q   <= sys_d;
            bd_q    <= bd_d;
            PPB_SEL_OUT   <= sys_ppb;
            INSTRUCTION_CODE_BUS_SEL_OUT <= code_pick_i;
        end
    end

    always_comb begin
        CODE_RSP_OUT = code_q;
        SYS_RSP_OUT  = sys_q;
        BD_RSP_OUT   = bd_q;
    end

endmodule

// File: verif/dbsa_monitor.sv
// checker: grant, latency and steering relations at the arbiter ports
module dbsa_monitor (
    // requests and modes
    input wire logic                MCLK_IN,
    input wire logic                RSTN_IN,
    input wire logic [1:0]          MODE_L_IN,
    input wire logic [1:0]          MODE_U_IN,
    input wire dbsa_pkg::dbsa_req_t INSTRUCTION_CODE_BUS_REQ_IN,
    input wire dbsa_pkg::dbsa_req_t DATA_CODE_BUS_REQ_IN,
    input wire dbsa_pkg::dbsa_req_t SYS_REQ_IN,
    input wire dbsa_pkg::dbsa_req_t BD_REQ_IN,
    // answers
    input wire dbsa_pkg::dbsa_rsp_t CODE_RSP_OUT,
    input wire dbsa_pkg::dbsa_rsp_t SYS_RSP_OUT,
    input wire dbsa_pkg::dbsa_rsp_t BD_RSP_OUT,
    input wire logic                PPB_SEL_OUT,
    input wire logic                INSTRUCTION_CODE_BUS_SEL_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    function automatic logic hit(dbsa_pkg::dbsa_req_t r, logic [31:0] lo, hi);
        return r.valid && r.addr >= lo && r.addr <= hi;
    endfunction
    logic dl, bl, bu, su, si;
    assign dl = hit(DATA_CODE_BUS_REQ_IN, dbsa_pkg::SRAM_L_LO, dbsa_pkg::SRAM_L_HI);
    assign bl = hit(BD_REQ_IN, dbsa_pkg::SRAM_L_LO, dbsa_pkg::SRAM_L_HI);
    assign bu = hit(BD_REQ_IN, dbsa_pkg::SRAM_U_LO, dbsa_pkg::SRAM_U_HI);
    assign su = hit(SYS_REQ_IN, dbsa_pkg::SRAM_U_LO, dbsa_pkg::SRAM_U_HI)
        && !SYS_REQ_IN.ifetch;
    assign si = hit(SYS_REQ_IN, dbsa_pkg::SRAM_U_LO, dbsa_pkg::SRAM_U_HI)
        && SYS_REQ_IN.ifetch;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RSTN_IN);
    chk_data_code_bus_fast: assert property (dl && (MODE_L_IN == 2'h0 || !bl)
        |=> CODE_RSP_OUT.done) else $error("code access slow");
    chk_sys_data: assert property (su && (MODE_U_IN == 2'h0 || !bu)
        |=> SYS_RSP_OUT.done) else $error("system data slow");
    chk_sys_ifetch: assert property (si && !$past(si)
        && MODE_U_IN == 2'h0 |=> !SYS_RSP_OUT.done ##1 SYS_RSP_OUT.done)
        else $error("system fetch wait wrong");
    chk_bd_fixed: assert property (bl && MODE_L_IN == 2'h1
        |=> BD_RSP_OUT.done) else $error("backdoor not first");
    chk_bd_yield: assert property (bu && su && MODE_U_IN == 2'h0
        |=> !BD_RSP_OUT.done) else $error("backdoor beat core");
    chk_rr_single: assert property (dl && bl && MODE_L_IN == 2'h2
        |=> CODE_RSP_OUT.done != BD_RSP_OUT.done) else $error("rr grant");
    chk_alias_err: assert property (hit(BD_REQ_IN,
        dbsa_pkg::DRAM_AL_LO, dbsa_pkg::DRAM_AL_HI)
        |=> BD_RSP_OUT.err && !BD_RSP_OUT.done) else $error("alias open");
    chk_ppb_sel: assert property (hit(SYS_REQ_IN,
        dbsa_pkg::PPB_LO, dbsa_pkg::PPB_HI) |=> PPB_SEL_OUT)
        else $error("private range not steered");
    cover property (dl && bl && MODE_L_IN == 2'h2);
    cover property (si && MODE_U_IN == 2'h0);
    cover property (bu && su && MODE_U_IN == 2'h3);
    cover property (dl && bl && MODE_L_IN == 2'h1);
endmodule

// File: verif/dbsa_master.sv
// partner: a bus master that holds its request until it is answered
module dbsa_master (
    // clock and load
    input  wire logic                clk_in,
    input  wire logic                load_in,
    input  wire dbsa_pkg::dbsa_req_t req_in,
    // answer side
    input  wire logic                ack_in,
    output dbsa_pkg::dbsa_req_t      req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req_out = '0;
    // released lines show inverted values so stale data never passes
    always @(negedge clk_in) begin
        if (load_in) begin
            req_out <= req_in;
        end else if (ack_in) begin
            req_out <= {1'b0, ~req_out[$bits(req_out)-2:0]};
        end
    end
endmodule

// File: verif/tb_top.sv
// testbench: table-driven latency and arbitration checks
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int ml, mu, ia, da, sa, sf, ba;
                    int li, ld, ls, lb;} dbsa_row_t;
    logic                mclk = 1'b0;
    logic                rst_n = 1'b0;
    logic                load = 1'b0;
    logic [1:0]          mode_l = 2'h2;
    logic [1:0]          mode_u = 2'h2;
    dbsa_pkg::dbsa_req_t q_i = '0, q_d = '0, q_s = '0, q_b = '0;
    dbsa_pkg::dbsa_req_t r_i, r_d, r_s, r_b;
    dbsa_pkg::dbsa_rsp_t c_rsp, s_rsp, b_rsp;
    dbsa_pkg::dbsa_req_t wr_l, wr_u;
    logic [31:0]         rdv[4];
    logic                ppb_sel, isel;
    logic [3:0]          dn;
    int                  bad_count = 0, num_checks = 0, lat[4];
    dbsa_row_t           rows[14];
    logic [31:0]         base[6];
    assign dn = {b_rsp.done, s_rsp.done,
                 c_rsp.done & !isel, c_rsp.done & isel};
    always #5 mclk = ~mclk;
    dbsa_master m_i (.clk_in(mclk), .load_in(load), .req_in(q_i),
        .ack_in(dn[0]), .req_out(r_i));
    dbsa_master m_d (.clk_in(mclk), .load_in(load), .req_in(q_d),
        .ack_in(dn[1]), .req_out(r_d));
    dbsa_master m_s (.clk_in(mclk), .load_in(load), .req_in(q_s),
        .ack_in(dn[2]), .req_out(r_s));
    dbsa_master m_b (.clk_in(mclk), .load_in(load), .req_in(q_b),
        .ack_in(dn[3] | b_rsp.err), .req_out(r_b));
    dbsa_arbiter DUT (.MCLK_IN(mclk), .RSTN_IN(rst_n), .MODE_L_IN(mode_l),
        .MODE_U_IN(mode_u), .INSTRUCTION_CODE_BUS_REQ_IN(r_i), .DATA_CODE_BUS_REQ_IN(r_d),
        .SYS_REQ_IN(r_s), .BD_REQ_IN(r_b), .CODE_RSP_OUT(c_rsp),
        .SYS_RSP_OUT(s_rsp), .BD_RSP_OUT(b_rsp), .PPB_SEL_OUT(ppb_sel),
        .INSTRUCTION_CODE_BUS_SEL_OUT(isel));
    function automatic dbsa_pkg::dbsa_req_t mk(int c, int f, int n);
        mk = '0;
        mk.valid = (c != 0);
        mk.ifetch = f[0];
        mk.addr = base[c] + 32'(4 * n);
    endfunction
    task automatic check(string what, logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic load_all(dbsa_pkg::dbsa_req_t i, d, s, b);
        @(negedge mclk);
        {q_i, q_d, q_s, q_b} <= {i, d, s, b};
        load <= 1'b1;
        @(negedge mclk);
        load <= 1'b0;
    endtask
    // each row runs alone; unanswered requests are withdrawn afterwards
    task automatic go(dbsa_pkg::dbsa_req_t i, d, s, b);
        lat = '{default: 0};
        rdv = '{default: '0};
        load_all(i, d, s, b);
        for (int k = 1; k <= 6; k++) begin
            @(posedge mclk);
            #1;
            foreach (lat[j]) if (lat[j] == 0 && dn[j] === 1'b1) begin
                lat[j] = k;
                rdv[j] = (j == 3) ? b_rsp.rdata :
                         (j == 2) ? s_rsp.rdata : c_rsp.rdata;
            end
        end
        load_all('0, '0, '0, '0);
    endtask
    task automatic run(int n);
        dbsa_row_t w;
        w = rows[n];
        mode_l <= 2'(w.ml);
        mode_u <= 2'(w.mu);
        go(mk(w.ia, 1, n), mk(w.da, 0, n), mk(w.sa, w.sf, n),
            mk(w.ba, 0, n));
        check("instruction_code_bus latency", lat[0], w.li);
        check("data_code_bus latency", lat[1], w.ld);
        check("system latency", lat[2], w.ls);
        check("backdoor latency", lat[3], w.lb);
    endtask
    initial begin
        base = '{32'h0, dbsa_pkg::SRAM_L_LO, dbsa_pkg::SRAM_U_LO,
            dbsa_pkg::NVM_LO, dbsa_pkg::PPB_LO, dbsa_pkg::DRAM_AL_LO};
        rows = '{'{2,2,1,1,0,0,0,2,1,0,0}, '{2,0,0,0,2,1,0,0,0,2,0},
            '{2,2,0,1,2,0,0,0,1,1,0}, '{2,2,0,1,0,0,2,0,1,0,1},
            '{2,2,0,0,2,0,1,0,0,1,1}, '{2,2,0,1,0,0,1,0,1,0,2},
            '{2,2,0,1,0,0,1,0,2,0,1}, '{2,3,0,0,2,0,2,0,0,2,1},
            '{2,3,0,0,2,0,2,0,0,2,1}, '{2,3,0,0,2,0,2,0,0,2,1},
            '{2,3,0,0,2,0,2,0,0,1,2}, '{2,0,0,0,2,0,2,0,0,1,2},
            '{2,2,0,3,4,0,5,0,0,0,0}, '{1,2,0,1,0,0,1,0,2,0,1}};
        repeat (8) @(negedge mclk);
        rst_n <= 1'b1;
        wr_l = mk(1, 0, 20);
        wr_l.write = 1'b1;
        wr_l.wdata = 32'h5a5a_1c00;
        wr_u = mk(2, 0, 20);
        wr_u.write = 1'b1;
        wr_u.wdata = 32'ha5a5_2000;
        foreach (rows[n]) run(n);
        // core wins this contest, leaving the backdoor favoured next
        run(5);
        // both banks written at once, then read back crosswise
        go('0, '0, wr_u, wr_l);
        check("system write latency", lat[2], 1);
        check("backdoor write latency", lat[3], 1);
        go('0, mk(1, 0, 20), '0, mk(2, 0, 20));
        check("lower bank word", rdv[1], wr_l.wdata);
        check("upper bank word", rdv[3], wr_u.wdata);
        // mid-run reset must bring back round robin with the core first
        rst_n <= 1'b0;
        repeat (8) @(negedge mclk);
        rst_n <= 1'b1;
        run(5);
        results();
    end
endmodule
bind dbsa_arbiter dbsa_monitor mon (.MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN),
    .MODE_L_IN(MODE_L_IN), .MODE_U_IN(MODE_U_IN),
    .INSTRUCTION_CODE_BUS_REQ_IN(INSTRUCTION_CODE_BUS_REQ_IN), .DATA_CODE_BUS_REQ_IN(DATA_CODE_BUS_REQ_IN),
    .SYS_REQ_IN(SYS_REQ_IN), .BD_REQ_IN(BD_REQ_IN),
    .CODE_RSP_OUT(CODE_RSP_OUT), .SYS_RSP_OUT(SYS_RSP_OUT),
    .BD_RSP_OUT(BD_RSP_OUT), .PPB_SEL_OUT(PPB_SEL_OUT),
    .INSTRUCTION_CODE_BUS_SEL_OUT(INSTRUCTION_CODE_BUS_SEL_OUT));
